// ===== rtl/sysref_window_pkg.sv
// package: register map, field layout, reset values and types of the block
package sysref_window_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0]  IDX_EDGE_MAP_LOW  = 8'h2c; // map bits 7..0
  localparam logic [7:0]  IDX_EDGE_MAP_MID  = 8'h2d; // map bits 15..8
  localparam logic [7:0]  IDX_EDGE_MAP_HIGH = 8'h2e; // map bits 23..16
  localparam logic [7:0]  IDX_WINDOW_CTRL   = 8'h30; // pick, step, mode, lanes
  localparam logic [7:0]  IDX_FRAME_PERIOD  = 8'h31; // counter period
  localparam logic [7:0]  IDX_CAPTURE_STAT  = 8'h32; // capture status
  // byte addresses derived from the indices
  localparam logic [9:0]  ADDR_EDGE_MAP_LOW  = {IDX_EDGE_MAP_LOW, 2'b00};
  localparam logic [9:0]  ADDR_EDGE_MAP_MID  = {IDX_EDGE_MAP_MID, 2'b00};
  localparam logic [9:0]  ADDR_EDGE_MAP_HIGH = {IDX_EDGE_MAP_HIGH, 2'b00};
  localparam logic [9:0]  ADDR_WINDOW_CTRL   = {IDX_WINDOW_CTRL, 2'b00};
  localparam logic [9:0]  ADDR_FRAME_PERIOD  = {IDX_FRAME_PERIOD, 2'b00};
  localparam logic [9:0]  ADDR_CAPTURE_STAT  = {IDX_CAPTURE_STAT, 2'b00};
  // geometry
  localparam int          MAP_BITS   = 24;   // candidate sampling delays
  localparam int          PICK_BITS  = 4;    // selects taps 0..15
  localparam int          MAX_LANES  = 8;    // serial lanes
  localparam int          PERIOD_W   = 16;   // frame counter width
  // window control field positions
  localparam int          POS_PICK   = 0;    // bits 3..0
  localparam int          POS_FINE   = 4;    // bit 4
  localparam int          POS_ENC    = 5;    // bit 5
  localparam int          POS_LANES  = 8;    // bits 11..8, lane count 1..8
  // reset values
  localparam logic [3:0]  RST_PICK   = 4'h0;
  localparam logic        RST_FINE   = 1'b1;   // fine steps by default
  localparam logic        RST_ENC    = 1'b0;   // 8b/10b by default
  localparam logic [3:0]  RST_LANES  = 4'h8;
  localparam logic [15:0] RST_PERIOD = 16'h0020;
  localparam logic [31:0] ZERO_WORD  = 32'h0000_0000;
  // ahb transfer type bits
  localparam logic [1:0]  HTRANS_NONSEQ = 2'b10;

  // line encoding modes
  typedef enum logic [0:0]
  {
    ENC_8B10B  = 1'b0,
    ENC_64B66B = 1'b1
  } enc_mode_t;

  // software control carried as one bundle
  typedef struct packed
  {
    logic [3:0] lanes;     // active lane count
    enc_mode_t  enc;       // line encoding
    logic       fine;      // fine delay step
    logic [3:0] pick;      // chosen sampling tap
  } window_ctrl_t;
endpackage

// ===== rtl/sysref_window_capture.sv
// sysref window capture: edge map, tap pick, frame counter reset, ahb regs
//
// Register access over AHB-Lite is this design's own decision.
`timescale 1ns/100ps
`default_nettype none

// Contract
// - latch reference on deterministic clock edge
// - record reference position in 24-bit map
// - map one marks risky delay, zero valid
// - map end bits always read one
// - pick value is index of sampled tap
// - pick reaches only taps zero to fifteen
// - fine step bit narrows delay spacing
// - captured reference resets frame counter
// - 64b/66b ignores sync request pin
// - up to eight serial lanes
// - 8b/10b or 64b/66b line encoding
module sysref_window_capture
  import sysref_window_pkg::*;
(
  input  wire logic                         clk,
  input  wire logic                         nrst,
  // ahb-lite slave
  input  wire logic                         hsel,
  input  wire logic [31:0]                  haddr,
  input  wire logic [1:0]                   htrans,
  input  wire logic                         hwrite,
  input  wire logic [2:0]                   hsize,
  input  wire logic [31:0]                  hwdata,
  input  wire logic                         hready,
  output logic [31:0]                       hrdata,
  output logic                              hreadyout,
  output logic                              hresp,
  // reference sampled by each delayed clock instance, asynchronous
  input  wire logic [23:0]                  ref_tap_samples,
  // receiver sync request pin, active low, asynchronous
  input  wire logic                         sync_request_pin_n,
  // delay line step control
  output logic                              fine_delay_step,
  // captured reference and frame boundaries
  output logic                              ref_captured,
  output logic                              lmfc_boundary,
  output logic                              lemc_boundary,
  // link layer steering
  output logic                              transport_mode_select,
  output logic                              sync_request_active,
  output logic                              sync_header_embed,
  output logic [7:0]                        lane_enable
);
  import sysref_window_pkg::*;

  // bus data phase state
  logic                  dphase_wr_r;    // write pending in data phase
  logic [9:0]            dphase_addr_r;  // latched byte address
  logic [31:0]           rdata_r;        // read answer
  // software registers
  window_ctrl_t          ctrl_r;         // pick, step, mode, lanes
  logic [PERIOD_W-1:0]   period_r;       // frame counter period
  // synchronisers
  logic [23:0]           tap_s1_r;       // first stage, read only by s2
  logic [23:0]           tap_s2_r;       // synced tap samples
  logic                  sync_s1_r;      // first stage
  logic                  sync_s2_r;      // synced sync request
  // map and capture
  logic [23:0]           map_nxt;        // map from current tap view
  logic [23:0]           map_r;          // held edge map
  logic                  refresh;        // an edge lies in the window
  logic                  picked;         // tap chosen by pick
  logic                  picked_d_r;     // previous picked value
  logic                  capture_edge;   // rising edge of picked tap
  logic [PERIOD_W-1:0]   cnt_r;          // local frame counter
  logic [15:0]           capture_cnt_r;  // number of captures seen
  logic                  aphase;         // address phase accepted
  logic [31:0]           read_word;      // read mux

  // accepted address phase
  assign aphase = hsel & hready & htrans[1];

  // zero wait state, always okay
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = rdata_r;

  // read mux, unmapped reads as zero
  always_comb
  begin
    read_word = ZERO_WORD;
    case (haddr[9:0])
      ADDR_EDGE_MAP_LOW:  read_word = {24'h00_0000, map_r[7:0]};
      ADDR_EDGE_MAP_MID:  read_word = {24'h00_0000, map_r[15:8]};
      ADDR_EDGE_MAP_HIGH: read_word = {24'h00_0000, map_r[23:16]};
      ADDR_WINDOW_CTRL:   read_word = {20'h0_0000, ctrl_r.lanes, 2'b00,
                                       ctrl_r.enc, ctrl_r.fine,
                                       ctrl_r.pick};
      ADDR_FRAME_PERIOD:  read_word = {16'h0000, period_r};
      ADDR_CAPTURE_STAT:  read_word = {15'h0000, picked_d_r, capture_cnt_r};
      default:            read_word = ZERO_WORD;
    endcase
    if (haddr[31:10] != 22'h00_0000)
    begin
      read_word = ZERO_WORD;
    end
  end

  // address phase capture and read answer
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      dphase_wr_r   <= 1'b0;
      dphase_addr_r <= 10'h000;
      rdata_r       <= ZERO_WORD;
    end
    else if (hready)
    begin
      dphase_wr_r   <= aphase & hwrite & (haddr[31:10] == 22'h00_0000);
      dphase_addr_r <= haddr[9:0];
      if (aphase && !hwrite)
      begin
        rdata_r <= read_word;
      end
    end
  end

  // software writes in the data phase
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      ctrl_r.pick  <= RST_PICK;
      ctrl_r.fine  <= RST_FINE;
      ctrl_r.enc   <= enc_mode_t'(RST_ENC);
      ctrl_r.lanes <= RST_LANES;
      period_r     <= RST_PERIOD;
    end
    else if (dphase_wr_r)
    begin
      case (dphase_addr_r)
        ADDR_WINDOW_CTRL:
        begin
          ctrl_r.pick <= hwdata[POS_PICK +: PICK_BITS];
          ctrl_r.fine <= hwdata[POS_FINE];
          ctrl_r.enc  <= enc_mode_t'(hwdata[POS_ENC]);
          // lane count clamped to 1..8
          if (hwdata[POS_LANES +: 4] == 4'h0)
          begin
            ctrl_r.lanes <= 4'h1;
          end
          else if (hwdata[POS_LANES +: 4] > 4'(MAX_LANES))
          begin
            ctrl_r.lanes <= 4'(MAX_LANES);
          end
          else
          begin
            ctrl_r.lanes <= hwdata[POS_LANES +: 4];
          end
        end
        ADDR_FRAME_PERIOD:
        begin
          // zero period would underflow the wrap compare to 16'hffff, keep at least one
          period_r <= (hwdata[15:0] == 16'h0000) ? 16'h0001 : hwdata[15:0];
        end
        default:
        begin
          period_r <= period_r;
        end
      endcase
    end
  end

  // two-flop synchronisers for the pin inputs
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      tap_s1_r  <= 24'h00_0000;
      tap_s2_r  <= 24'h00_0000;
      sync_s1_r <= 1'b1;
      sync_s2_r <= 1'b1;
    end
    else
    begin
      tap_s1_r  <= ref_tap_samples;
      tap_s2_r  <= tap_s1_r;
      sync_s1_r <= sync_request_pin_n;
      sync_s2_r <= sync_s1_r;
    end
  end

  // map bit set where a neighbouring tap disagrees
  assign map_nxt[0]  = 1'b1;
  assign map_nxt[23] = 1'b1;
  genvar gi;
  generate
    for (gi = 1; gi < MAP_BITS - 1; gi = gi + 1)
    begin : g_map
      assign map_nxt[gi] = (tap_s2_r[gi-1] != tap_s2_r[gi]) |
                           (tap_s2_r[gi] != tap_s2_r[gi+1]);
    end
  endgenerate

  // an edge of the reference lies inside the tap window
  assign refresh = (|tap_s2_r) & ~(&tap_s2_r);

  // held map, updated on every observed edge
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      map_r <= 24'hff_ffff;
    end
    else if (refresh)
    begin
      map_r <= map_nxt;
    end
  end

  // tap chosen by the pick field
  assign picked       = tap_s2_r[ctrl_r.pick];
  assign capture_edge = picked & ~picked_d_r;

  // capture of the chosen tap and edge count
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      picked_d_r    <= 1'b0;
      capture_cnt_r <= 16'h0000;
    end
    else
    begin
      picked_d_r <= picked;
      if (capture_edge)
      begin
        capture_cnt_r <= capture_cnt_r + 16'h0001;
      end
    end
  end

  // local multiframe / extended multiblock counter
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      cnt_r <= 16'h0000;
    end
    else if (capture_edge)
    begin
      cnt_r <= 16'h0000;
    end
    else if (cnt_r >= period_r - 16'h0001)
    begin
      cnt_r <= 16'h0000;
    end
    else
    begin
      cnt_r <= cnt_r + 16'h0001;
    end
  end

  // boundary pulses per encoding
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      lmfc_boundary <= 1'b0;
      lemc_boundary <= 1'b0;
      ref_captured  <= 1'b0;
    end
    else
    begin
      lmfc_boundary <= capture_edge & (ctrl_r.enc == ENC_8B10B);
      lemc_boundary <= capture_edge & (ctrl_r.enc == ENC_64B66B);
      ref_captured  <= capture_edge;
      // wrap pulse lands as the counter returns to zero, like a capture
      if (!capture_edge && cnt_r >= period_r - 16'h0001)
      begin
        lmfc_boundary <= (ctrl_r.enc == ENC_8B10B);
        lemc_boundary <= (ctrl_r.enc == ENC_64B66B);
      end
    end
  end

  // link steering outputs from flops
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      fine_delay_step       <= RST_FINE;
      transport_mode_select <= RST_ENC;
      sync_request_active   <= 1'b0;
      sync_header_embed     <= 1'b0;
      lane_enable           <= 8'h00;
    end
    else
    begin
      fine_delay_step       <= ctrl_r.fine;
      transport_mode_select <= ctrl_r.enc;
      sync_request_active   <= ~sync_s2_r & (ctrl_r.enc == ENC_8B10B);
      sync_header_embed     <= (ctrl_r.enc == ENC_64B66B);
      lane_enable           <= 8'((9'h001 << ctrl_r.lanes) - 9'h001);
    end
  end

  // ---- assertions
  sequence s_edge_seen;
    refresh;
  endsequence

  property p_map_ends;
    @(posedge clk) disable iff (!nrst) map_r[0] && map_r[23];
  endproperty
  a_map_ends: assert property (p_map_ends)
    else $error("map end bits not one");

  property p_map_refresh;
    @(posedge clk) disable iff (!nrst)
      s_edge_seen |=> (map_r == $past(map_nxt));
  endproperty
  a_map_refresh: assert property (p_map_refresh)
    else $error("map not refreshed on edge");

  property p_map_hold;
    @(posedge clk) disable iff (!nrst)
      !refresh |=> $stable(map_r);
  endproperty
  a_map_hold: assert property (p_map_hold)
    else $error("map changed without edge");

  property p_map_valid;
    @(posedge clk) disable iff (!nrst)
      refresh && (tap_s2_r[2:0] == 3'b000 || tap_s2_r[2:0] == 3'b111)
      |=> !map_r[1];
  endproperty
  a_map_valid: assert property (p_map_valid)
    else $error("uniform taps marked risky");

  property p_pick_sample;
    @(posedge clk) disable iff (!nrst)
      ##1 picked_d_r == $past(tap_s2_r[ctrl_r.pick]);
  endproperty
  a_pick_sample: assert property (p_pick_sample)
    else $error("wrong tap sampled");

  sequence s_capture;
    capture_edge ##1 (ref_captured && cnt_r == 16'h0000);
  endsequence

  property p_counter_reset;
    @(posedge clk) disable iff (!nrst)
      capture_edge |-> s_capture;
  endproperty
  a_counter_reset: assert property (p_counter_reset)
    else $error("counter not reset by capture");

  property p_boundary_mode;
    @(posedge clk) disable iff (!nrst)
      capture_edge && ctrl_r.enc == ENC_64B66B
      |=> lemc_boundary && !lmfc_boundary;
  endproperty
  a_boundary_mode: assert property (p_boundary_mode)
    else $error("wrong boundary for mode");

  property p_sync_ignored;
    @(posedge clk) disable iff (!nrst)
      ctrl_r.enc == ENC_64B66B |=> !sync_request_active;
  endproperty
  a_sync_ignored: assert property (p_sync_ignored)
    else $error("sync pin used in 64b66b");

  property p_fine_follows;
    @(posedge clk) disable iff (!nrst)
      $changed(ctrl_r.fine) |=> fine_delay_step == $past(ctrl_r.fine);
  endproperty
  a_fine_follows: assert property (p_fine_follows)
    else $error("fine step not applied");

  property p_lanes_max;
    @(posedge clk) disable iff (!nrst)
      nrst |=> ($countones(lane_enable) == int'($past(ctrl_r.lanes)))
        && ctrl_r.lanes <= 4'(MAX_LANES);
  endproperty
  a_lanes_max: assert property (p_lanes_max)
    else $error("lane enable mismatch");

  property p_edge_latency;
    @(posedge clk) disable iff (!nrst)
      $rose(picked) |-> capture_edge ##1 !capture_edge;
  endproperty
  a_edge_latency: assert property (p_edge_latency)
    else $error("capture edge not deterministic");

endmodule

`default_nettype wire

// ===== bench/ref_source_model.sv
// partner model: reference seen across the delay taps, receiver sync pin
`timescale 1ns/100ps
`default_nettype none
module ref_source_model
(
  input  wire logic        clk,
  input  wire logic        run,     // periodic reference on
  input  wire logic        split,   // hold a static edge in the taps
  input  wire logic [4:0]  pos,     // first tap still showing old level
  input  wire logic        sync_lo, // receiver asks for resync
  output logic [23:0]      taps,
  output logic             sync_n
);
  logic       lvl_r = 1'b0; // level at the smallest delay
  logic       old_r = 1'b0; // level one cycle earlier
  logic [5:0] cnt_r = 6'h00; // half period counter
  // periodic clock while run is high; period 80 is ten frames of 8
  always_ff @(posedge clk)
  begin
    cnt_r <= run ? cnt_r + 6'h01 : 6'h00;
    if (run && cnt_r == 6'h27)
    begin
      lvl_r <= ~lvl_r;
      cnt_r <= 6'h00;
    end
    old_r <= split ? ~lvl_r : lvl_r; // static edge keeps taps apart
  end
  // small delays see the new level first
  always_comb
    for (int i = 0; i < 24; i++)
      taps[i] = (i < pos) ? lvl_r : old_r;
  // active low resync request; block sync comes from headers otherwise
  assign sync_n = ~sync_lo;
endmodule
`default_nettype wire

// ===== bench/sysref_window_capture_bench.sv
// bench: register, edge map, capture and link steering checks
`timescale 1ns/100ps
`default_nettype none
module sysref_window_capture_bench;
  import sysref_window_pkg::*;
  logic        clk, nrst, hsel, hwrite, hready, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, got_q;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [23:0] taps;
  logic        sync_n, fine, cap, lmfc, lemc, mode, sreq, hdr;
  logic [7:0]  lanes;
  logic        run, split, sync_lo, exp_mode, arm;
  logic [4:0]  pos;
  logic [31:0] exp_q[$], msk_q[$]; // expected read words and masks
  int          err_count, checked, seed, cycles, gap, cgap, p, k;
  event        seen;               // a read word has arrived
  assign hready = hreadyout;
  // device under test
  sysref_window_capture i_dut (.clk(clk), .nrst(nrst), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .ref_tap_samples(taps),
    .sync_request_pin_n(sync_n), .fine_delay_step(fine),
    .ref_captured(cap), .lmfc_boundary(lmfc), .lemc_boundary(lemc),
    .transport_mode_select(mode), .sync_request_active(sreq),
    .sync_header_embed(hdr), .lane_enable(lanes));
  // far side
  ref_source_model i_src (.clk(clk), .run(run), .split(split),
    .pos(pos), .sync_lo(sync_lo), .taps(taps), .sync_n(sync_n));
  // clock, 50 ns period
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  // compare and count
  task automatic cmp(input string what, input logic [31:0] e, g);
    checked++;
    if (g !== e)
    begin
      err_count++;
      $display("BAD %s exp %h got %h", what, e, g);
    end
  endtask
  // verdict and end of run
  task automatic complete_run();
    $display("counts: checked %0d err_count %0d", checked, err_count);
    if (err_count == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // one single ahb transfer, address then data phase
  task automatic bus(input logic w, input logic [31:0] a, d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    got_q = hrdata;
  endtask
  // read with expectation noted first
  task automatic rd(input logic [31:0] a, e, m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    bus(1'b0, a, ZERO_WORD);
    ->seen;
  endtask
  // watcher for read words
  always @(seen)
    cmp("hrdata", exp_q.pop_front(), got_q & msk_q.pop_front());
  // watcher for capture and boundary pulses
  always @(posedge clk)
    if (nrst === 1'b1)
    begin
      gap++;
      cgap++;
      if (cap === 1'b1)
      begin
        cmp("lmfc_boundary", 32'(!exp_mode), 32'(lmfc));
        cmp("lemc_boundary", 32'(exp_mode), 32'(lemc));
        if (arm)
          cmp("capture gap", 32'd80, 32'(cgap));
        cgap = 0;
      end
      else if (arm && (lmfc | lemc) === 1'b1)
        cmp("boundary gap", 32'd8, 32'(gap));
      if ((lmfc | lemc) === 1'b1)
        gap = 0;
    end
  // hang guard
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      err_count++;
      complete_run();
    end
  end
  // main sequence
  initial
  begin
    {err_count, checked, cycles, gap, cgap} = '0;
    seed = 74;
    {nrst, hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'b010;
    {run, split, sync_lo, exp_mode, arm} = '0;
    pos = 5'd8;
    repeat (10) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    #1;
    cmp("fine_delay_step", 32'h1, 32'(fine));
    cmp("lane_enable", 32'h0000_00ff, 32'(lanes));
    rd(ADDR_EDGE_MAP_LOW, 32'h0000_00ff, '1);
    rd(ADDR_EDGE_MAP_HIGH, 32'h0000_00ff, '1);
    rd(ADDR_WINDOW_CTRL, 32'h0000_0810, '1);
    rd(ADDR_FRAME_PERIOD, 32'h0000_0020, '1);
    rd(32'h0000_03fc, ZERO_WORD, '1);
    $display("test reset done");
    // lane counts including the clamped ends
    for (int n = 0; n < 10; n++)
    begin
      k = (n == 0) ? 1 : (n > 8) ? 8 : n;
      bus(1'b1, ADDR_WINDOW_CTRL, 32'(n) << 8 | 32'h10);
      rd(ADDR_WINDOW_CTRL, 32'(k) << 8 | 32'h10, '1);
      cmp("lane_enable", (32'h1 << k) - 1, 32'(lanes));
    end
    $display("test lanes done");
    // both encodings, both steps, sync pin up and down
    for (int i = 0; i < 4; i++)
    begin
      bus(1'b1, ADDR_WINDOW_CTRL, 32'h800 | i << 4);
      sync_lo <= i[0];
      repeat (6) @(posedge clk);
      #1;
      cmp("mode", 32'(i[1]), 32'(mode));
      cmp("header", 32'(i[1]), 32'(hdr));
      cmp("sync_req", 32'(i[0] & !i[1]), 32'(sreq));
      cmp("fine_delay_step", 32'(i[0]), 32'(fine));
    end
    sync_lo <= 1'b0;
    $display("test modes done");
    // static edges at random places; map follows the latest one
    bus(1'b1, ADDR_WINDOW_CTRL, 32'h810);
    split <= 1'b1;
    for (int j = 0; j < 4; j++)
    begin
      p = 2 + $unsigned($random(seed)) % 20;
      pos <= 5'(p);
      repeat (6) @(posedge clk);
      bus(1'b1, ADDR_EDGE_MAP_LOW, ZERO_WORD);
      k = 24'h80_0001 | 24'h3 << (p - 1);
      rd(ADDR_EDGE_MAP_LOW, 32'(k[7:0]), '1);
      rd(ADDR_EDGE_MAP_MID, 32'(k[15:8]), '1);
      rd(ADDR_EDGE_MAP_HIGH, 32'(k[23:16]), '1);
    end
    // each pick samples its own tap; edge after tap 7
    pos <= 5'd8;
    for (int t = 0; t < 16; t++)
    begin
      bus(1'b1, ADDR_WINDOW_CTRL, 32'h810 | t);
      rd(ADDR_CAPTURE_STAT, 32'(t >= 8) << 16, 32'h0001_0000);
    end
    split <= 1'b0;
    $display("test map done");
    // periodic reference resets the frame counters in both encodings
    pos <= 5'd12;
    bus(1'b1, ADDR_FRAME_PERIOD, ZERO_WORD);
    rd(ADDR_FRAME_PERIOD, 32'h0000_0001, '1);
    bus(1'b1, ADDR_FRAME_PERIOD, 32'h0000_0008);
    for (int m = 0; m < 2; m++)
    begin
      bus(1'b1, ADDR_WINDOW_CTRL, 32'h815 | m << 5);
      exp_mode = m[0];
      run <= 1'b1;
      for (int t = 0; t < 200 && cap !== 1'b1; t++) @(posedge clk);
      cmp("ref_captured", 32'h1, 32'(cap));
      @(posedge clk);
      #1;
      arm = 1'b1;
      repeat (400) @(posedge clk);
      #1;
      arm = 1'b0;
      run <= 1'b0;
    end
    $display("test capture done");
    complete_run();
  end
endmodule
`default_nettype wire
